// ### fifo_pkg.sv
// ============================================================================
// fifo_pkg: constants, register layout and types of the dual-clock FIFO
// assumes: included first in compile order; read by dual_clock_fifo and test_dual_clock_fifo
// ============================================================================
// How it works
// [R1] depth is a power of two, 2^depth_exp; pointer widths derive from it
// [R2] elaboration stops for depth_exp below two, so depth is at least four
// [R3] exact mode: push-side full only when all 2^N entries hold unread words
// [R4] conservative mode: full may rise with 2^N-3 words stored
// [R5] overflow protection on: a push while full is dropped, contents kept
// [R6] underflow protection on: a pop while empty is dropped
// [R7] producer holds its push request low when the clear is released
// [R8] producer drops its push request in the same cycle full is seen
// [R9] consumer drops its pop request in the same cycle empty is seen
// [R10] used counts are N bits, wrap to zero at exactly 2^N words
// [R11] extra-msb option: counts gain a bit and show 2^N when full
// [R12] flags and counts use the far pointer only after synchronisation
// [R13] separate stage counts set each pointer synchroniser length
// [R14] pushes taken on push clock edges, pops on the independent pop clock
// [R15] pop-side empty is registered, falls after the write pointer crosses
// [R16] secondary flags: empty resynchronised to push clock, full to pop clock
// [R17] normal mode loads the word at the pop; lookahead shows it beforehand
// [R18] pointers cross domains in gray code, one bit changing per step
package fifo_pkg;

   // ==========================================================================
   // default geometry and options
   localparam int DEF_DEPTH_EXP = 4;
   localparam int DEF_DATA_W = 8;
   localparam int MIN_DEPTH_EXP = 2;
   localparam int DEF_SYNC_STAGES = 3;
   localparam int MIN_SYNC_STAGES = 2;
   localparam int FLAG_SYNC_STAGES = 2;
   localparam int CONSERV_MARGIN = 3;

   // ==========================================================================
   // register bus
   localparam int APB_ADDR_W = 12;
   localparam int APB_DATA_W = 32;
   localparam logic [11:0] OFS_STATUS = 12'h000;
   localparam logic [11:0] OFS_MASK = 12'h004;
   localparam logic [11:0] OFS_LEVEL = 12'h008;
   localparam int LVL_FULL_BIT = 16;
   localparam int LVL_EMPTY_BIT = 17;

   // ==========================================================================
   // event bits shared by status and mask registers
   localparam int EVT_W = 3;
   typedef struct packed
   {
      logic full_hit;
      logic underflow;
      logic overflow;
   } evt_t;
   localparam evt_t EVT_NONE = 3'h0;

endpackage

// ### sync_pipe.sv
// sync_pipe: chain of flip-flops carrying a value into another clock domain
// assumes: the value changes at most one bit at a time (gray or a level)
`timescale 1ns/100ps
module sync_pipe
#(
   parameter int width = 1,
   parameter int stages = 2
)
(
   // destination clock and reset
   input wire logic clk,
   input wire logic rstn,
   // value from the far domain and its synchronised copy
   input wire logic [width-1:0] d,
   output logic [width-1:0] q
);

   logic [stages-1:0][width-1:0] pipe_ff;

   // shift the far value in; only the next stage reads the first one
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pipe_ff <= '0;
      else
         pipe_ff <= {pipe_ff[stages-2:0], d};
   end

   assign q = pipe_ff[stages-1];

endmodule

// ### dual_clock_fifo.sv
// dual_clock_fifo: flip-flop FIFO with separate push and pop clocks, gray
// pointer crossing, flags and used counts in each domain, and an APB
// status block with an interrupt on the push clock.
// assumes: producer runs on CORE_CLK, consumer on POP_CLK; both keep the
// request rules on clear release and on full or empty.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/100ps
module dual_clock_fifo
   import fifo_pkg::*;
#(
   parameter int depth_exp = DEF_DEPTH_EXP,
   parameter int data_w = DEF_DATA_W,
   parameter bit exact_full = 1'b1,
   parameter bit overflow_protect = 1'b1,
   parameter bit underflow_protect = 1'b1,
   parameter bit extra_msb = 1'b0,
   parameter bit lookahead_select = 1'b0,
   parameter int push_sync_stages = DEF_SYNC_STAGES,
   parameter int pop_sync_stages = DEF_SYNC_STAGES
)
(
   // push clock (also the bus clock) and asynchronous clear
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // push side
   input wire logic PUSH_REQ,
   input wire logic [data_w-1:0] PUSH_DATA,
   output logic PUSH_FULL,
   output logic PUSH_EMPTY,
   output logic [depth_exp:0] PUSH_USED,
   // pop side
   input wire logic POP_CLK,
   input wire logic POP_REQ,
   output logic [data_w-1:0] POP_DATA,
   output logic POP_EMPTY,
   output logic POP_FULL,
   output logic [depth_exp:0] POP_USED,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [APB_ADDR_W-1:0] PADDR,
   input wire logic [APB_DATA_W-1:0] PWDATA,
   output logic [APB_DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // interrupt
   output logic IRQ
);

   // ==========================================================================
   // geometry
   localparam int ptr_w = depth_exp + 1;
   localparam logic [ptr_w-1:0] depth_words = ptr_w'(1) << depth_exp; // R1
   localparam logic [ptr_w-1:0] full_floor = depth_words - ptr_w'(CONSERV_MARGIN);

   // stop elaboration on an illegal configuration
   if (depth_exp < MIN_DEPTH_EXP)
   begin : g_bad_depth
      $error("fifo depth must be at least four entries"); // R2
   end
   if (push_sync_stages < MIN_SYNC_STAGES || pop_sync_stages < MIN_SYNC_STAGES)
   begin : g_bad_sync
      $error("synchroniser needs at least two stages");
   end

   // ==========================================================================
   // gray conversions
   function automatic logic [ptr_w-1:0] bin_to_gray(input logic [ptr_w-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [ptr_w-1:0] gray_to_bin(input logic [ptr_w-1:0] g);
      logic [ptr_w-1:0] b;
      b = g;
      for (int i = ptr_w - 2; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // count shown at a port: wraps at full unless the extra bit is kept
   function automatic logic [ptr_w-1:0] shown_count(input logic [ptr_w-1:0] c);
      if (extra_msb)
         return c; // R11
      else
         return {1'b0, c[depth_exp-1:0]}; // R10
   endfunction

   // ==========================================================================
   // storage
   logic [data_w-1:0] mem [depth_words];

   // ==========================================================================
   // push domain declarations
   logic [ptr_w-1:0] wr_bin_ff;
   logic [ptr_w-1:0] wr_gray_ff;
   logic [ptr_w-1:0] nxt_wr_bin;
   logic [ptr_w-1:0] rd_gray_seen;
   logic [ptr_w-1:0] rd_bin_seen;
   logic [ptr_w-1:0] nxt_wr_used;
   logic nxt_wr_full;
   logic wr_full_ff;
   logic [ptr_w-1:0] wr_used_ff;
   logic push_ok;

   // ==========================================================================
   // pop domain declarations
   logic [ptr_w-1:0] rd_bin_ff;
   logic [ptr_w-1:0] rd_gray_ff;
   logic [ptr_w-1:0] nxt_rd_bin;
   logic [ptr_w-1:0] wr_gray_seen;
   logic [ptr_w-1:0] wr_bin_seen;
   logic [ptr_w-1:0] nxt_rd_used;
   logic rd_empty_ff;
   logic [ptr_w-1:0] rd_used_ff;
   logic [data_w-1:0] pop_data_ff;
   logic pop_ok;
   logic unf_tgl_ff;

   // ==========================================================================
   // push side: accept, store, advance
   // a full fifo drops the push only when protection is on
   assign push_ok = PUSH_REQ & (~wr_full_ff | ~overflow_protect); // R5
   assign nxt_wr_bin = wr_bin_ff + ptr_w'(push_ok);

   // storage write on the push clock; data holds no reset
   always_ff @(posedge CORE_CLK)
   begin
      if (push_ok)
         mem[wr_bin_ff[depth_exp-1:0]] <= PUSH_DATA; // R14
   end

   // write pointer, binary for addressing and gray for the crossing
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         wr_bin_ff <= '0;
         wr_gray_ff <= '0;
      end
      else
      begin
         wr_bin_ff <= nxt_wr_bin; // R14
         wr_gray_ff <= bin_to_gray(nxt_wr_bin); // R18
      end
   end

   // read pointer brought over to the push clock
   sync_pipe
   #(
      .width(ptr_w),
      .stages(pop_sync_stages)
   )
   u_rd_ptr_sync
   (
      .clk(CORE_CLK),
      .rstn(RSTN),
      .d(rd_gray_ff),
      .q(rd_gray_seen) // R13
   );

   // fill level and full from the synchronised read pointer only
   assign rd_bin_seen = gray_to_bin(rd_gray_seen); // R12
   assign nxt_wr_used = nxt_wr_bin - rd_bin_seen;
   assign nxt_wr_full = exact_full ? (nxt_wr_used == depth_words) : // R3
                        (nxt_wr_used >= full_floor); // R4

   // full flag and count registered; a stale read pointer errs toward full
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         wr_full_ff <= 1'b0;
         wr_used_ff <= '0;
      end
      else
      begin
         wr_full_ff <= nxt_wr_full;
         wr_used_ff <= shown_count(nxt_wr_used); // R10
      end
   end

   // the producer must read PUSH_FULL combinationally and drop its request
   assign PUSH_FULL = wr_full_ff; // R8
   assign PUSH_USED = wr_used_ff;

   // ==========================================================================
   // pop side: accept, advance, present data
   // an empty fifo drops the pop only when protection is on
   assign pop_ok = POP_REQ & (~rd_empty_ff | ~underflow_protect); // R6
   assign nxt_rd_bin = rd_bin_ff + ptr_w'(pop_ok);

   // read pointer, binary for addressing and gray for the crossing
   always_ff @(posedge POP_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rd_bin_ff <= '0;
         rd_gray_ff <= '0;
      end
      else
      begin
         rd_bin_ff <= nxt_rd_bin; // R14
         rd_gray_ff <= bin_to_gray(nxt_rd_bin); // R18
      end
   end

   // write pointer brought over to the pop clock
   sync_pipe
   #(
      .width(ptr_w),
      .stages(push_sync_stages)
   )
   u_wr_ptr_sync
   (
      .clk(POP_CLK),
      .rstn(RSTN),
      .d(wr_gray_ff),
      .q(wr_gray_seen) // R13
   );

   // empty and count from the synchronised write pointer only
   assign wr_bin_seen = gray_to_bin(wr_gray_seen); // R12
   assign nxt_rd_used = wr_bin_seen - nxt_rd_bin;

   // empty registered on the pop clock; it falls once a push has crossed
   always_ff @(posedge POP_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         rd_empty_ff <= 1'b1;
         rd_used_ff <= '0;
      end
      else
      begin
         rd_empty_ff <= (bin_to_gray(nxt_rd_bin) == wr_gray_seen); // R15
         rd_used_ff <= shown_count(nxt_rd_used); // R10
      end
   end

   // output word: loaded at the pop, or kept showing the oldest word
   always_ff @(posedge POP_CLK or negedge RSTN)
   begin
      if (!RSTN)
         pop_data_ff <= '0;
      else if (lookahead_select)
         pop_data_ff <= mem[nxt_rd_bin[depth_exp-1:0]]; // R17
      else if (pop_ok)
         pop_data_ff <= mem[rd_bin_ff[depth_exp-1:0]]; // R17
   end

   // the consumer must read POP_EMPTY combinationally and drop its request
   assign POP_EMPTY = rd_empty_ff; // R9
   assign POP_USED = rd_used_ff;
   assign POP_DATA = pop_data_ff;

   // ==========================================================================
   // secondary flags, a further crossing each way
   sync_pipe
   #(
      .width(1),
      .stages(FLAG_SYNC_STAGES)
   )
   u_empty_to_push
   (
      .clk(CORE_CLK),
      .rstn(RSTN),
      .d(rd_empty_ff),
      .q(PUSH_EMPTY) // R16
   );

   sync_pipe
   #(
      .width(1),
      .stages(FLAG_SYNC_STAGES)
   )
   u_full_to_pop
   (
      .clk(POP_CLK),
      .rstn(RSTN),
      .d(wr_full_ff),
      .q(POP_FULL) // R16
   );

   // ==========================================================================
   // event capture
   logic unf_tgl_seen;
   logic unf_tgl_last_ff;
   logic full_last_ff;
   evt_t evt_now;

   // each pop attempt on an empty fifo flips a toggle for the push clock
   always_ff @(posedge POP_CLK or negedge RSTN)
   begin
      if (!RSTN)
         unf_tgl_ff <= 1'b0;
      else if (POP_REQ & rd_empty_ff)
         unf_tgl_ff <= ~unf_tgl_ff;
   end

   sync_pipe
   #(
      .width(1),
      .stages(FLAG_SYNC_STAGES)
   )
   u_unf_sync
   (
      .clk(CORE_CLK),
      .rstn(RSTN),
      .d(unf_tgl_ff),
      .q(unf_tgl_seen)
   );

   // history for edge detection on the push clock
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         unf_tgl_last_ff <= 1'b0;
         full_last_ff <= 1'b0;
      end
      else
      begin
         unf_tgl_last_ff <= unf_tgl_seen;
         full_last_ff <= wr_full_ff;
      end
   end

   // event pulses; overflow stays high every cycle a push is requested while full
   always_comb
   begin
      evt_now = EVT_NONE;
      evt_now.overflow = PUSH_REQ & wr_full_ff;
      evt_now.underflow = unf_tgl_seen ^ unf_tgl_last_ff;
      evt_now.full_hit = wr_full_ff & ~full_last_ff;
   end

   // ==========================================================================
   // apb slave, zero wait states
   logic setup_ph;
   logic access_ph;
   logic hit_status;
   logic hit_mask;
   logic hit_level;
   logic mapped;
   logic [APB_DATA_W-1:0] rd_mux;
   logic [APB_DATA_W-1:0] prdata_ff;
   logic pslverr_ff;
   evt_t status_ff;
   evt_t mask_ff;
   evt_t status_clr;
   logic irq_ff;

   assign setup_ph = PSEL & ~PENABLE;
   assign access_ph = PSEL & PENABLE;
   assign hit_status = (PADDR == OFS_STATUS);
   assign hit_mask = (PADDR == OFS_MASK);
   assign hit_level = (PADDR == OFS_LEVEL);
   assign mapped = hit_status | hit_mask | hit_level;

   // read value chosen by address; unused bits read as zero
   always_comb
   begin
      rd_mux = '0;
      if (hit_status)
         rd_mux[EVT_W-1:0] = status_ff;
      else if (hit_mask)
         rd_mux[EVT_W-1:0] = mask_ff;
      else if (hit_level)
      begin
         rd_mux[ptr_w-1:0] = wr_used_ff;
         rd_mux[LVL_FULL_BIT] = wr_full_ff;
         rd_mux[LVL_EMPTY_BIT] = PUSH_EMPTY;
      end
   end

   // read data and error latched in the setup cycle, shown in the access
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         prdata_ff <= '0;
         pslverr_ff <= 1'b0;
      end
      else if (setup_ph)
      begin
         prdata_ff <= PWRITE ? '0 : rd_mux;
         pslverr_ff <= ~mapped;
      end
   end

   // mask register
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
         mask_ff <= EVT_NONE;
      else if (access_ph & PWRITE & hit_mask)
         mask_ff <= PWDATA[EVT_W-1:0];
   end

   // sticky status, write one to clear; a new event wins over the clear
   assign status_clr = (access_ph & PWRITE & hit_status) ? evt_t'(PWDATA[EVT_W-1:0]) :
                       EVT_NONE;

   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
         status_ff <= EVT_NONE;
      else
         status_ff <= (status_ff & ~status_clr) | evt_now;
   end

   // interrupt level while any unmasked status bit is set
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
         irq_ff <= 1'b0;
      else
         irq_ff <= |(status_ff & mask_ff);
   end

   assign PREADY = 1'b1;
   assign PRDATA = prdata_ff;
   assign PSLVERR = pslverr_ff;
   assign IRQ = irq_ff;

endmodule

// ### fifo_checker_sva.sv
// fifo_checker_sva: port assertions for dual_clock_fifo
// assumes: bound into dual_clock_fifo; POP_CLK unrelated to CORE_CLK
`timescale 1ns/100ps
module fifo_checker
#(
   parameter int depth_exp = 4,
   parameter int data_w = 8
)
(
   // clocks and clear
   input wire logic CORE_CLK,
   input wire logic POP_CLK,
   input wire logic RSTN,
   // push side
   input wire logic PUSH_REQ,
   input wire logic PUSH_FULL,
   input wire logic PUSH_EMPTY,
   input wire logic [depth_exp:0] PUSH_USED,
   // pop side
   input wire logic POP_REQ,
   input wire logic [data_w-1:0] POP_DATA,
   input wire logic POP_EMPTY,
   input wire logic POP_FULL,
   input wire logic [depth_exp:0] POP_USED
);
   // ==========================================================================
   // helpers
   localparam logic [depth_exp:0] DEPTH = (depth_exp + 1)'(1) << depth_exp;
   logic [1:0] core_age_ff;
   logic [1:0] pop_age_ff;
   // edges since clear release, so delayed copies never look into reset
   always_ff @(posedge CORE_CLK or negedge RSTN)
      if (!RSTN) core_age_ff <= 2'h0;
      else if (core_age_ff != 2'h3) core_age_ff <= core_age_ff + 2'h1;
   always_ff @(posedge POP_CLK or negedge RSTN)
      if (!RSTN) pop_age_ff <= 2'h0;
      else if (pop_age_ff != 2'h3) pop_age_ff <= pop_age_ff + 2'h1;
   // first word pushed into an empty fifo
   sequence s_first_push;
      PUSH_USED == 0 && PUSH_REQ && POP_EMPTY;
   endsequence

   // ==========================================================================
   // assertions
   a_full_exact: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      PUSH_FULL == (PUSH_USED == DEPTH)) else $error("full flag disagrees with count");
   a_full_keeps: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      PUSH_FULL && PUSH_REQ |=> PUSH_USED <= $past(PUSH_USED))
      else $error("push taken while full");
   a_push_counts: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      PUSH_REQ && !PUSH_FULL |=> PUSH_USED != 0) else $error("push not counted");
   a_first_unseen: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      s_first_push |=> POP_EMPTY [*2]) else $error("word seen before crossing");
   a_empty_copy: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      core_age_ff == 2'h3 |-> PUSH_EMPTY == $past(POP_EMPTY, 2)) else $error("push empty copy");
   a_full_copy: assert property (@(posedge POP_CLK) disable iff (!RSTN)
      pop_age_ff == 2'h3 |-> POP_FULL == $past(PUSH_FULL, 2)) else $error("pop full copy");
   a_empty_count: assert property (@(posedge POP_CLK) disable iff (!RSTN)
      POP_EMPTY == (POP_USED == 0)) else $error("pop empty disagrees with count");
   a_underflow_hold: assert property (@(posedge POP_CLK) disable iff (!RSTN)
      POP_REQ && POP_EMPTY |=> $stable(POP_DATA)) else $error("pop taken while empty");
endmodule

bind dual_clock_fifo fifo_checker #(.depth_exp(depth_exp), .data_w(data_w)) u_fifo_chk
(
   .CORE_CLK, .POP_CLK, .RSTN, .PUSH_REQ, .PUSH_FULL, .PUSH_EMPTY, .PUSH_USED,
   .POP_REQ, .POP_DATA, .POP_EMPTY, .POP_FULL, .POP_USED
);

// ### pop_consumer.sv
// pop_consumer: consumer logic on the pop clock draining the fifo
// assumes: pop clock made by the bench; normal read timing
`timescale 1ns/100ps
module pop_consumer
#(
   parameter int data_w = 8
)
(
   // pop clock and clear
   input wire logic pop_clk,
   input wire logic rstn,
   // bench controls: want to pop, pop regardless of empty
   input wire logic want,
   input wire logic rude,
   // fifo pop side
   input wire logic pop_empty,
   input wire logic [data_w-1:0] pop_data,
   output logic pop_req,
   // popped word, valid for one pop clock
   output logic got_valid,
   output logic [data_w-1:0] got_data
);
   // empty drops the request combinationally; rude breaks that on purpose
   assign pop_req = (want && !pop_empty) || rude;
   // a taken pop shows its word on pop_data during the next cycle
   always_ff @(posedge pop_clk or negedge rstn)
      if (!rstn) got_valid <= 1'b0;
      else got_valid <= want && !pop_empty;
   assign got_data = pop_data;
endmodule

// ### test_dual_clock_fifo.sv
// test_dual_clock_fifo: self-checking bench for dual_clock_fifo
// assumes: package, design, checker and pop_consumer compiled before it
`timescale 1ns/100ps
module test_dual_clock_fifo;
   import fifo_pkg::*;
   // ==========================================================================
   // signals
   localparam int N = 4;
   localparam int DEPTH = 16;
   logic core_clk = 1'b0;
   logic pop_clk = 1'b0;
   logic rstn = 1'b0;
   logic push_want = 1'b0;
   logic rude_push = 1'b0;
   logic want = 1'b0;
   logic rude = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] push_data = 8'h00;
   logic push_req, push_full, push_empty, pop_req, pop_empty, pop_full;
   logic got_valid, pready, pslverr, irq, err;
   logic [N:0] push_used, pop_used;
   logic [7:0] pop_data, got_data, ahead_data;
   logic [31:0] prdata, rd;
   logic [7:0] exp_q[$];
   int errors = 0;
   int num_checks = 0;

   // clocks: pop clock rising edges never meet core clock edges
   initial forever #10 core_clk = ~core_clk;
   initial forever #7.1 pop_clk = ~pop_clk;
   // producer drops its request as soon as full is seen
   assign push_req = (push_want && !push_full) || rude_push;

   dual_clock_fifo #(.depth_exp(N), .extra_msb(1'b1), .push_sync_stages(3),
      .pop_sync_stages(2)) DUT
   (
      .CORE_CLK(core_clk), .RSTN(rstn), .PUSH_REQ(push_req), .PUSH_DATA(push_data),
      .PUSH_FULL(push_full), .PUSH_EMPTY(push_empty), .PUSH_USED(push_used),
      .POP_CLK(pop_clk), .POP_REQ(pop_req), .POP_DATA(pop_data), .POP_EMPTY(pop_empty),
      .POP_FULL(pop_full), .POP_USED(pop_used), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq)
   );
   // lookahead twin fed the same requests: its word must stand before each pop
   dual_clock_fifo #(.depth_exp(N), .extra_msb(1'b1), .lookahead_select(1'b1),
      .push_sync_stages(3), .pop_sync_stages(2)) DUT_AHEAD
   (
      .CORE_CLK(core_clk), .RSTN(rstn), .PUSH_REQ(push_req), .PUSH_DATA(push_data),
      .PUSH_FULL(), .PUSH_EMPTY(), .PUSH_USED(), .POP_CLK(pop_clk), .POP_REQ(pop_req),
      .POP_DATA(ahead_data), .POP_EMPTY(), .POP_FULL(), .POP_USED(), .PSEL(1'b0),
      .PENABLE(1'b0), .PWRITE(1'b0), .PADDR(12'h000), .PWDATA(32'h0), .PRDATA(),
      .PREADY(), .PSLVERR(), .IRQ()
   );
   pop_consumer #(.data_w(8)) u_cons
   (
      .pop_clk(pop_clk), .rstn(rstn), .want(want), .rude(rude), .pop_empty(pop_empty),
      .pop_data(pop_data), .pop_req(pop_req), .got_valid(got_valid), .got_data(got_data)
   );

   // ==========================================================================
   // shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic push_words(input int n, input logic [7:0] base);
      int k;
      k = 0;
      @(posedge core_clk);
      push_data <= base;
      push_want <= 1'b1;
      while (k < n)
      begin
         @(posedge core_clk);
         if (push_req)
         begin
            exp_q.push_back(base + 8'(k));
            k++;
            push_data <= base + 8'(k);
         end
      end
      push_want <= 1'b0;
   endtask
   task automatic drain();
      want <= 1'b1;
      repeat (400) if (exp_q.size() != 0) @(posedge core_clk);
      want <= 1'b0;
      check("left", exp_q.size(), 0);
      repeat (8) @(posedge core_clk);
   endtask
   // every popped word must be the oldest one pushed
   always @(posedge pop_clk)
   begin
      if (got_valid === 1'b1)
         check("pop_data", got_data, exp_q.size() ? exp_q.pop_front() : 32'hffff);
      // a pop taken now acknowledges the word the lookahead twin already shows
      if (pop_req === 1'b1 && pop_empty === 1'b0)
         check("ahead_data", ahead_data, exp_q.size() ? exp_q[0] : 32'hffff);
   end

   // ==========================================================================
   // scenarios
   task automatic t_reset();
      check("pop_empty", pop_empty, 1'b1);
      check("push_empty", push_empty, 1'b1);
      check("push_used", push_used, 0);
      apb(1'b0, OFS_MASK, 0);
      check("mask", rd, 0);
      $display("test reset done");
   endtask
   task automatic t_fill();
      push_words(DEPTH, 8'h10);
      @(posedge core_clk);
      check("push_used", push_used, DEPTH);
      check("push_full", push_full, 1'b1);
      rude_push <= 1'b1;
      push_data <= 8'hee;
      @(posedge core_clk);
      rude_push <= 1'b0;
      repeat (4) @(posedge core_clk);
      check("push_used", push_used, DEPTH);
      check("pop_full", pop_full, 1'b1);
      apb(1'b0, OFS_LEVEL, 0);
      check("level", rd, 32'h0001_0010);
      apb(1'b0, OFS_STATUS, 0);
      check("status", rd, 32'h5);
      check("irq", irq, 1'b0);
      apb(1'b1, OFS_MASK, 32'h1);
      repeat (2) @(posedge core_clk);
      check("irq", irq, 1'b1);
      apb(1'b1, OFS_STATUS, 32'h5);
      repeat (2) @(posedge core_clk);
      check("irq", irq, 1'b0);
      drain();
      check("pop_used", pop_used, 0);
      check("push_empty", push_empty, 1'b1);
      check("push_used", push_used, 0);
      $display("test fill done");
   endtask
   task automatic t_under();
      @(posedge pop_clk);
      rude <= 1'b1;
      @(posedge pop_clk);
      rude <= 1'b0;
      repeat (6) @(posedge core_clk);
      check("pop_used", pop_used, 0);
      apb(1'b0, OFS_STATUS, 0);
      check("status", rd, 32'h2);
      check("irq", irq, 1'b0);
      apb(1'b0, 12'h00c, 0);
      check("slverr", err, 1'b1);
      check("unmapped", rd, 0);
      $display("test underflow done");
   endtask
   task automatic t_stream();
      fork
         push_words(40, 8'h40);
         repeat (12)
         begin
            want <= 1'b1;
            repeat (5) @(posedge pop_clk);
            want <= 1'b0;
            repeat (3) @(posedge pop_clk);
         end
      join
      drain();
      $display("test stream done");
   endtask

   // ==========================================================================
   // run control
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_reset();
      t_fill();
      t_under();
      t_stream();
      complete_run();
   end
   initial
   begin
      #200000;
      errors++;
      complete_run();
   end
endmodule
